// *** design/asc_defs.svh ***
// Behaviour
// (R01) Request bytes 0-1 reserved, byte 2 read/write opcode
// (R02) Byte 3 size, 4-7 address, 8-15 payload
// (R03) Reply byte 0 mirrors status, byte 1 reserved
// (R04) Reply byte 2 echoes request opcode
// (R05) Reply bytes 4-7 echo target address
// (R06) Reply byte 3 size, 8-15 data or fault
// (R07) 1008 encoder reset: prepared, 5 s, incremental servo-off
// (R08) 100E offset tune: unprepared, power on, idle motor
// (R09) 1013 multiturn limit: prepared, incremental needs alarm
// (R10) Master selects service: write 2000, size 0002
// (R11) Normally accepted request sets status to 1
// (R12) Prepared services send 0002 to 2001 first
// (R13) Master starts service: 0001 to 2001
// (R14) 0000 to 2000 stops, acknowledged with 1
// (R15) Master sends stop after any error reply
// (R16) Ten seconds without request stops selected service
// (R17) Status 0,1,2,3 done/error codes, 255 executing
// (R18) Writing request starts processing; reply read separately
// (R19) Unknown service code answered with error, nothing starts
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ==========================================================
// Message field positions (bit offsets, byte 0 in bits 7:0)
`define ASC_OP_LSB        8
`define ASC_OP_POS        16
`define ASC_SIZE_POS      24
`define ASC_ADDR_POS      32
`define ASC_DATA_POS      64
`define ASC_MSG_W         128

// ==========================================================
// Opcodes, addresses, payload values
`define ASC_OP_READ       8'h00
`define ASC_OP_WRITE      8'h01
`define ASC_ADDR_SELECT   32'h00002000
`define ASC_ADDR_STEP     32'h00002001
`define ASC_SIZE_WORD     8'h02
`define ASC_SIZE_NONE     8'h00
`define ASC_STEP_PREP     16'h0002
`define ASC_STEP_EXEC     16'h0001
`define ASC_SVC_STOP      16'h0000
`define ASC_SVC_ENC_RST   16'h1008
`define ASC_SVC_OFS_TUNE  16'h100E
`define ASC_SVC_MT_LIMIT  16'h1013

// ==========================================================
// Status values
`define ASC_ST_OK_NODATA  8'h00
`define ASC_ST_OK_DATA    8'h01
`define ASC_ST_ERR_NODATA 8'h02
`define ASC_ST_ERR_DATA   8'h03
`define ASC_ST_BUSY       8'hFF

// ==========================================================
// Fault codes placed in reply payload
`define ASC_F_OPCODE      16'h0001
`define ASC_F_ADDR        16'h0002
`define ASC_F_SIZE        16'h0003
`define ASC_F_SERVICE     16'h0004
`define ASC_F_SEQUENCE    16'h0005
`define ASC_F_CONDITION   16'h0006
`define ASC_F_VALUE       16'h0007
`define ASC_F_EXEC_TMO    16'h0008

// ==========================================================
// Timing
`define ASC_CLK_HZ        25000000
`define ASC_SEL_TMO_S     10
`define ASC_EXEC_TMO_S    5
`define ASC_TMR_W         28

`endif

// *** design/asc_pkg.sv ***
`include "asc_defs.svh"

package asc_pkg;

  // ==========================================================
  // Device sequence states
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_SELECTED,
    ASC_PREPARED,
    ASC_RUNNING
  } asc_dev_state_e;

  // Master sequence states
  typedef enum logic [2:0] {
    ASC_M_IDLE,
    ASC_M_SEL,
    ASC_M_PREP,
    ASC_M_EXEC,
    ASC_M_STOP
  } asc_mst_state_e;

  typedef logic [`ASC_MSG_W-1:0] asc_msg_t;

  // Whole device state
  typedef struct packed {
    asc_dev_state_e         st;
    logic [15:0]            svc;
    logic                   pend;
    asc_msg_t               req;
    logic [7:0]             status;
    asc_msg_t               rsp;
    logic [`ASC_TMR_W-1:0]  tmr;
    logic                   start;
    logic                   abort;
    logic [4:0]             sync1;
    logic [4:0]             sync2;
  } asc_dev_s;

  // Whole master state
  typedef struct packed {
    asc_mst_state_e st;
    logic           valid;
    asc_msg_t       msg;
    logic           waiting;
    logic           seen_busy;
    logic [15:0]    svc;
    logic           had_err;
    logic           busy;
    logic           ok;
    logic           fail;
  } asc_mst_s;

  // ==========================================================
  // Services that want the preparation step
  function automatic logic asc_needs_prep(input logic [15:0] svc);
    return (svc == `ASC_SVC_ENC_RST) || (svc == `ASC_SVC_MT_LIMIT);
  endfunction

  // Build a request word
  function automatic asc_msg_t asc_make_req(input logic [7:0]  op,
                                            input logic [31:0] addr,
                                            input logic [7:0]  size,
                                            input logic [15:0] data);
    return {48'h000000000000, data, addr, size, op, 16'h0000};
  endfunction

endpackage

// *** design/asc_link_if.sv ***
`timescale 1ns/10ps

// ==========================================================
`include "asc_defs.svh"

// Request / reply link between master and drive
interface asc_link_if;
  logic                   req_valid;   // One-cycle request write strobe
  logic [`ASC_MSG_W-1:0]  req_msg;     // Request message
  logic [7:0]             rsp_status;  // Status entry
  logic [`ASC_MSG_W-1:0]  rsp_msg;     // Reply entry

  modport dev (
    input  req_valid,
    input  req_msg,
    output rsp_status,
    output rsp_msg
  );

  modport mst (
    output req_valid,
    output req_msg,
    input  rsp_status,
    input  rsp_msg
  );
endinterface

// *** design/asc_device.sv ***
`timescale 1ns/10ps
`include "asc_defs.svh"

// ==========================================================
// Drive end: interprets adjustment requests
module asc_device #(
  parameter logic [`ASC_TMR_W-1:0] SEL_CYCLES  = `ASC_TMR_W'(`ASC_SEL_TMO_S * `ASC_CLK_HZ),
  parameter logic [`ASC_TMR_W-1:0] EXEC_CYCLES = `ASC_TMR_W'(`ASC_EXEC_TMO_S * `ASC_CLK_HZ)
) (
  input  wire logic  CLOCK,
  input  wire logic  RESETN,
  asc_link_if.dev    LNK,
  input  wire logic  MAIN_POWER_ON,
  input  wire logic  SERVO_ON,
  input  wire logic  MOTOR_RUNNING,
  input  wire logic  INCREMENTAL_ENC,
  input  wire logic  MULTITURN_ALARM,
  input  wire logic  ADJ_DONE,
  output logic       ADJ_START,
  output logic       ADJ_ABORT,
  output logic [15:0] ADJ_SERVICE
);
  import asc_pkg::*;

  // ==========================================================
  // State
  asc_dev_s r;   // Registered state
  asc_dev_s n;   // Next state

  // Synchronised condition pins
  logic pwr_s;   // Main power present
  logic son_s;   // Servo on
  logic run_s;   // Motor turning
  logic inc_s;   // Incremental encoder fitted
  logic mta_s;   // Multiturn disagreement alarm

  assign pwr_s = r.sync2[0];
  assign son_s = r.sync2[1];
  assign run_s = r.sync2[2];
  assign inc_s = r.sync2[3];
  assign mta_s = r.sync2[4];

  // ==========================================================
  // Helpers
  // Reply word; byte 0 is patched with the status afterwards
  function automatic asc_msg_t build_reply(input asc_msg_t   req,
                                           input logic [7:0]  size,
                                           input logic [15:0] data);
    return {48'h000000000000, data,
            req[`ASC_ADDR_POS +: 32],           // (R05)
            size,                               // (R06)
            req[`ASC_OP_POS +: 8],              // (R04)
            16'h0000};
  endfunction

  // Known service codes
  function automatic logic svc_known(input logic [15:0] svc);
    return (svc == `ASC_SVC_ENC_RST) || (svc == `ASC_SVC_OFS_TUNE) ||
           (svc == `ASC_SVC_MT_LIMIT);
  endfunction

  // Execution refused by machine conditions
  function automatic logic svc_refused(input logic [15:0] svc,
                                       input logic        pwr,
                                       input logic        son,
                                       input logic        run,
                                       input logic        inc,
                                       input logic        mta);
    logic bad;
    bad = 1'b0;
    unique case (svc)
      `ASC_SVC_ENC_RST:  bad = inc && son;               // (R07)
      `ASC_SVC_OFS_TUNE: bad = !pwr || son || run;       // (R08)
      `ASC_SVC_MT_LIMIT: bad = inc && !mta;              // (R09)
      default:           bad = 1'b1;
    endcase
    return bad;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0]  op;     // Request opcode
    logic [7:0]  sz;     // Request payload size
    logic [31:0] addr;   // Request target address
    logic [15:0] dat;    // First payload word
    logic [15:0] fault;  // Nonzero on refusal
    logic        rd;     // Read answered with data
    logic [15:0] rd_val; // Read data
    logic        held;   // Execution started, reply deferred
    op     = r.req[`ASC_OP_POS +: 8];                  // (R01)
    sz     = r.req[`ASC_SIZE_POS +: 8];                // (R02)
    addr   = r.req[`ASC_ADDR_POS +: 32];
    dat    = r.req[`ASC_DATA_POS +: 16];
    fault  = 16'h0000;
    rd     = 1'b0;
    rd_val = 16'h0000;
    held   = 1'b0;

    n       = r;
    n.start = 1'b0;
    n.abort = 1'b0;
    n.pend  = 1'b0;
    // Two flip-flops ahead of any use of the pins
    n.sync1 = {MULTITURN_ALARM, INCREMENTAL_ENC, MOTOR_RUNNING, SERVO_ON, MAIN_POWER_ON};
    n.sync2 = r.sync1;

    // Shared down-counter for both timeouts
    if (r.tmr != '0) begin
      n.tmr = r.tmr - `ASC_TMR_W'(1);
    end

    // Counter expiry
    if (r.tmr == `ASC_TMR_W'(1)) begin
      if (r.st == ASC_RUNNING) begin
        // Engine overran its time budget
        n.st     = ASC_IDLE;
        n.abort  = 1'b1;
        n.status = `ASC_ST_ERR_DATA;
        n.rsp    = build_reply(r.req, `ASC_SIZE_WORD, `ASC_F_EXEC_TMO);
      end else if (r.st != ASC_IDLE && !r.pend) begin
        // Selection left idle too long; a request taken just now wins
        n.st    = ASC_IDLE;                             // (R16)
        n.abort = 1'b1;                                 // (R16)
      end
    end

    // Engine finished normally
    if (r.st == ASC_RUNNING && ADJ_DONE) begin
      n.st     = ASC_IDLE;
      n.tmr    = '0;
      n.status = `ASC_ST_OK_DATA;                      // (R11)
      n.rsp    = build_reply(r.req, `ASC_SIZE_NONE, 16'h0000);
    end

    // ==========================================================
    // Interpret the request captured last cycle
    if (r.pend) begin
      if (op == `ASC_OP_READ) begin
        // Reads report the selection and sequence step
        if (addr == `ASC_ADDR_SELECT) begin
          rd     = 1'b1;
          rd_val = r.svc;
        end else if (addr == `ASC_ADDR_STEP) begin
          rd     = 1'b1;
          rd_val = {14'h0000, r.st};
        end else begin
          fault = `ASC_F_ADDR;
        end
      end else if (op != `ASC_OP_WRITE) begin
        fault = `ASC_F_OPCODE;
      end else if (sz != `ASC_SIZE_WORD) begin
        fault = `ASC_F_SIZE;
      end else if (addr == `ASC_ADDR_SELECT) begin
        if (dat == `ASC_SVC_STOP) begin
          // Stop is legal in any step
          n.abort = (r.st != ASC_IDLE);                 // (R14)
          n.st    = ASC_IDLE;                           // (R14)
        end else if (r.st != ASC_IDLE) begin
          fault = `ASC_F_SEQUENCE;
        end else if (!svc_known(dat)) begin
          fault = `ASC_F_SERVICE;                       // (R19)
        end else begin
          n.st  = ASC_SELECTED;
          n.svc = dat;
        end
      end else if (addr == `ASC_ADDR_STEP) begin
        if (dat == `ASC_STEP_PREP) begin
          // Preparation only for services that want it
          if (r.st == ASC_SELECTED && asc_needs_prep(r.svc)) begin
            n.st = ASC_PREPARED;
          end else begin
            fault = `ASC_F_SEQUENCE;
          end
        end else if (dat == `ASC_STEP_EXEC) begin
          if (!((r.st == ASC_PREPARED) ||
                (r.st == ASC_SELECTED && !asc_needs_prep(r.svc)))) begin
            fault = `ASC_F_SEQUENCE;                    // (R07)
          end else if (svc_refused(r.svc, pwr_s, son_s, run_s, inc_s, mta_s)) begin
            fault = `ASC_F_CONDITION;
          end else begin
            n.st    = ASC_RUNNING;
            n.start = 1'b1;
            held    = 1'b1;
          end
        end else begin
          fault = `ASC_F_VALUE;
        end
      end else begin
        fault = `ASC_F_ADDR;
      end

      // Status and reply for this request
      if (held) begin
        n.status = `ASC_ST_BUSY;                        // (R17)
        n.tmr    = EXEC_CYCLES;                         // (R07)
      end else if (fault != 16'h0000) begin
        n.status = `ASC_ST_ERR_DATA;                    // (R17)
        n.rsp    = build_reply(r.req, `ASC_SIZE_WORD, fault); // (R06)
      end else if (rd) begin
        n.status = `ASC_ST_OK_DATA;
        n.rsp    = build_reply(r.req, `ASC_SIZE_WORD, rd_val);
      end else begin
        n.status = `ASC_ST_OK_DATA;                     // (R11)
        n.rsp    = build_reply(r.req, `ASC_SIZE_NONE, 16'h0000);
      end

      // A request leaving the drive selected or prepared restarts the selection watchdog
      if (n.st == ASC_SELECTED || n.st == ASC_PREPARED) begin
        n.tmr = SEL_CYCLES;                             // (R16)
      end else if (n.st == ASC_IDLE) begin
        n.tmr = '0;
      end
    end

    // ==========================================================
    // A written request is taken and shown busy
    if (LNK.req_valid) begin
      n.req    = LNK.req_msg;                           // (R18)
      n.pend   = 1'b1;                                  // (R18)
      n.status = `ASC_ST_BUSY;
    end

    // Reply byte 0 always tracks the status entry
    n.rsp[7:0]  = n.status;                             // (R03)
    n.rsp[15:8] = 8'h00;                                // (R03)
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '{st: ASC_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign LNK.rsp_status = r.status;
  assign LNK.rsp_msg    = r.rsp;
  assign ADJ_START      = r.start;
  assign ADJ_ABORT      = r.abort;
  assign ADJ_SERVICE    = r.svc;

endmodule

// *** design/asc_master.sv ***
`timescale 1ns/10ps
`include "asc_defs.svh"

// ==========================================================
// Master end: runs one whole adjustment sequence per go pulse
module asc_master (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  asc_link_if.mst          LNK,
  input  wire logic        CMD_GO,
  input  wire logic [15:0] CMD_SERVICE,
  output logic             SEQ_BUSY,
  output logic             SEQ_OK,
  output logic             SEQ_FAIL
);
  import asc_pkg::*;

  asc_mst_s r;   // Registered state
  asc_mst_s n;   // Next state

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic done;  // Reply for last request available
    done = r.waiting && r.seen_busy && (LNK.rsp_status != `ASC_ST_BUSY);

    n       = r;
    n.valid = 1'b0;

    // Busy must be seen first, the old status may linger one cycle
    if (r.waiting && LNK.rsp_status == `ASC_ST_BUSY) begin
      n.seen_busy = 1'b1;
    end

    unique case (r.st)
      ASC_M_IDLE: begin
        if (CMD_GO) begin
          // Select service
          n.st      = ASC_M_SEL;
          n.svc     = CMD_SERVICE;
          n.had_err = 1'b0;
          n.busy    = 1'b1;
          n.ok      = 1'b0;
          n.fail    = 1'b0;
          n.valid   = 1'b1;
          n.msg     = asc_make_req(`ASC_OP_WRITE, `ASC_ADDR_SELECT,
                                   `ASC_SIZE_WORD, CMD_SERVICE); // (R10)
        end
      end
      default: begin
        if (done) begin
          if (LNK.rsp_status != `ASC_ST_OK_DATA && r.st != ASC_M_STOP) begin
            // Abort after any error
            n.st      = ASC_M_STOP;
            n.had_err = 1'b1;
            n.valid   = 1'b1;
            n.msg     = asc_make_req(`ASC_OP_WRITE, `ASC_ADDR_SELECT,
                                     `ASC_SIZE_WORD, `ASC_SVC_STOP); // (R15)
          end else if (r.st == ASC_M_SEL && asc_needs_prep(r.svc)) begin
            n.st    = ASC_M_PREP;
            n.valid = 1'b1;
            n.msg   = asc_make_req(`ASC_OP_WRITE, `ASC_ADDR_STEP,
                                   `ASC_SIZE_WORD, `ASC_STEP_PREP); // (R12)
          end else if (r.st == ASC_M_SEL || r.st == ASC_M_PREP) begin
            n.st    = ASC_M_EXEC;
            n.valid = 1'b1;
            n.msg   = asc_make_req(`ASC_OP_WRITE, `ASC_ADDR_STEP,
                                   `ASC_SIZE_WORD, `ASC_STEP_EXEC); // (R13)
          end else begin
            // Finished, either run completed or stop acknowledged
            n.st   = ASC_M_IDLE;
            n.busy = 1'b0;
            n.ok   = !r.had_err && (LNK.rsp_status == `ASC_ST_OK_DATA);
            n.fail = r.had_err || (LNK.rsp_status != `ASC_ST_OK_DATA);
          end
        end
      end
    endcase

    // Each send arms a fresh wait
    if (n.valid) begin
      n.waiting   = 1'b1;
      n.seen_busy = 1'b0;
    end else if (n.st == ASC_M_IDLE) begin
      n.waiting = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '{st: ASC_M_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign LNK.req_valid = r.valid;
  assign LNK.req_msg   = r.msg;
  assign SEQ_BUSY      = r.busy;
  assign SEQ_OK        = r.ok;
  assign SEQ_FAIL      = r.fail;

endmodule

// *** bench/asc_link_chk.sv ***
`timescale 1ns/10ps
`include "asc_defs.svh"

// ==========================================================
// Link checker: master/drive request link, both ends design
module asc_link_chk (
  input wire logic                  CLOCK,
  input wire logic                  RESETN,
  input wire logic                  req_valid,
  input wire logic [`ASC_MSG_W-1:0] req_msg,
  input wire logic [7:0]            rsp_status,
  input wire logic [`ASC_MSG_W-1:0] rsp_msg
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // ==========================================================
  // Request shapes
  sequence sel_req;
    req_valid && (req_msg[63:32] == `ASC_ADDR_SELECT);
  endsequence

  sequence stop_req;
    sel_req ##0 (req_msg[79:64] == `ASC_SVC_STOP);
  endsequence

  // Local copies survive the two-cycle answer delay
  property p_op_echo;
    logic [7:0] op;
    (sel_req, op = req_msg[23:16]) |-> ##2 (rsp_msg[23:16] == op);
  endproperty

  property p_addr_echo;
    logic [31:0] ad;
    (sel_req, ad = req_msg[63:32]) |-> ##2 (rsp_msg[63:32] == ad);
  endproperty

  // ==========================================================
  // Assertions
  a_req_reserved: assert property (req_valid |-> req_msg[15:0] == 16'h0000)
    else $error("request reserved bytes not zero");
  a_req_size: assert property (req_valid |-> req_msg[31:24] == `ASC_SIZE_WORD)
    else $error("request size is not two");
  a_busy_mark: assert property (req_valid |=> rsp_status == `ASC_ST_BUSY)
    else $error("status not busy after request");
  a_no_overlap: assert property (rsp_status == `ASC_ST_BUSY |-> !req_valid)
    else $error("request sent while busy");
  a_status_mirror: assert property (rsp_msg[7:0] == rsp_status)
    else $error("reply byte 0 differs from status");
  a_byte1_reserved: assert property (rsp_msg[15:8] == 8'h00)
    else $error("reply byte 1 not zero");
  a_select_answer: assert property (sel_req |-> ##2 rsp_status inside {8'h01, 8'h03})
    else $error("select not answered in two cycles");
  a_stop_ack: assert property (stop_req |-> ##2 rsp_status == `ASC_ST_OK_DATA)
    else $error("stop not acknowledged with 1");
  a_op_echo: assert property (p_op_echo)
    else $error("opcode echo wrong");
  a_addr_echo: assert property (p_addr_echo)
    else $error("address echo wrong");
  a_error_frame: assert property (rsp_status == `ASC_ST_ERR_DATA |-> rsp_msg[31:24] == 8'h02)
    else $error("error reply size not two");
  a_status_legal: assert property (rsp_status inside {[8'h00:8'h03], 8'hFF})
    else $error("status value outside encoding");
endmodule

// *** bench/adjustment_service_command_tb.sv ***
`timescale 1ns/10ps
`include "asc_defs.svh"

// ==========================================================
// Bench: master against drive A, bench driver against drive B
module adjustment_service_command_tb;
  logic         clock;                      // 25 MHz
  logic         resetn;                     // Async, active low
  logic         pwr, son, run, inc, mta;    // Condition pins, shared
  logic         done;                       // Engine completion
  logic         go;                         // Sequence launch
  logic [15:0]  svc;                        // Service for master
  logic         busy, ok, fail;             // Master results
  logic         start_a, abort_a, start_b, abort_b;
  logic [15:0]  svc_a;
  logic [7:0]   st;                         // Last status on link B
  logic [127:0] rsp;                        // Last reply on link B
  int           mismatches;
  int           n_checks;
  int           starts_b;                   // Run starts seen on drive B

  asc_link_if link_a ();
  asc_link_if link_b ();

  asc_master asc_master_i (.CLOCK(clock), .RESETN(resetn), .LNK(link_a.mst), .CMD_GO(go),
    .CMD_SERVICE(svc), .SEQ_BUSY(busy), .SEQ_OK(ok), .SEQ_FAIL(fail));
  // Short watchdogs: 200 cycles select, 100 cycles run
  asc_device #(.SEL_CYCLES(28'h00000C8), .EXEC_CYCLES(28'h0000064)) asc_device_i (
    .CLOCK(clock), .RESETN(resetn), .LNK(link_a.dev), .MAIN_POWER_ON(pwr), .SERVO_ON(son),
    .MOTOR_RUNNING(run), .INCREMENTAL_ENC(inc), .MULTITURN_ALARM(mta), .ADJ_DONE(done),
    .ADJ_START(start_a), .ADJ_ABORT(abort_a), .ADJ_SERVICE(svc_a));
  // Second drive faces the bench so rule breaking can be commanded
  asc_device #(.SEL_CYCLES(28'h00000C8), .EXEC_CYCLES(28'h0000064)) asc_device_b_i (
    .CLOCK(clock), .RESETN(resetn), .LNK(link_b.dev), .MAIN_POWER_ON(pwr), .SERVO_ON(son),
    .MOTOR_RUNNING(run), .INCREMENTAL_ENC(inc), .MULTITURN_ALARM(mta), .ADJ_DONE(done),
    .ADJ_START(start_b), .ADJ_ABORT(abort_b), .ADJ_SERVICE());
  asc_link_chk asc_link_chk_i (.CLOCK(clock), .RESETN(resetn), .req_valid(link_a.req_valid),
    .req_msg(link_a.req_msg), .rsp_status(link_a.rsp_status), .rsp_msg(link_a.rsp_msg));

  // ==========================================================
  // Clock
  always #20 clock = ~clock;

  // Count run starts on drive B, cleared while in reset
  always @(posedge clock) starts_b <= !resetn ? 0 : starts_b + ((start_b === 1'b1) ? 1 : 0);

  // ==========================================================
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // One request on link B; waits past busy, bounded
  task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input logic [7:0] sz,
                      input logic [15:0] d, input logic [7:0] est, input logic [15:0] ed);
    int n;
    link_b.req_msg   <= {48'h000000000000, d, ad, sz, op, 16'h0000};
    link_b.req_valid <= 1'b1;
    @(posedge clock);
    link_b.req_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    n = 0;
    // Run requests stay busy until done or run timeout
    while (link_b.rsp_status === 8'hFF && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    st  = link_b.rsp_status;
    rsp = link_b.rsp_msg;
    check(st, est, "status");
    check(rsp[7:0], est, "byte 0");
    check(rsp[23:16], op, "op echo");
    check(rsp[63:32], ad, "addr echo");
    // Errors and reads carry a word, accepted writes none
    check(rsp[31:24], (est == 8'h03 || op == 8'h00) ? 8'h02 : 8'h00, "size");
    check(rsp[79:64], ed, "payload");
    $display("test xfer %h to %h done", d, ad);
    @(posedge clock);
  endtask

  // ==========================================================
  // Whole master sequence on link A; engine answers each start
  task automatic run_seq(input logic [15:0] s, input logic [4:0] pins, input logic exp_ok);
    int   n;
    logic started;
    logic aborted;
    {pwr, son, run, inc, mta} <= pins;
    svc <= s;
    started = 1'b0;
    aborted = 1'b0;
    // Pins pass two flops before the drive sees them
    repeat (3) @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    for (n = 0; n < 300; n++) begin
      @(posedge clock);
      done <= start_a;
      if (start_a === 1'b1) begin
        started = 1'b1;
      end
      // Stop of a selected service must tell the engine
      if (abort_a === 1'b1) begin
        aborted = 1'b1;
      end
      if (n > 2 && busy === 1'b0) begin
        break;
      end
    end
    check(busy, 1'b0, "busy");
    check(ok, exp_ok, "ok");
    check(fail, !exp_ok, "fail");
    check(started, exp_ok, "engine start");
    check(aborted, !exp_ok && (s inside {16'h1008, 16'h100E, 16'h1013}), "abort");
    if (exp_ok) begin
      check(svc_a, s, "service");
    end
    $display("test sequence %h done", s);
    @(posedge clock);
  endtask

  // ==========================================================
  // Watchdog: whole run needs some 600 cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    clock = 1'b0;
    resetn = 1'b0;
    {pwr, son, run, inc, mta} = 5'h10;
    done = 1'b0;
    go = 1'b0;
    svc = 16'h0000;
    link_b.req_valid = 1'b0;
    link_b.req_msg = 128'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    // Master runs: pins are {power, servo, running, incremental, alarm}
    run_seq(16'h100E, 5'h10, 1'b1);
    run_seq(16'h100E, 5'h00, 1'b0);
    run_seq(16'h100E, 5'h18, 1'b0);
    run_seq(16'h100E, 5'h14, 1'b0);
    run_seq(16'h1008, 5'h1A, 1'b0);
    run_seq(16'h1008, 5'h18, 1'b1);
    run_seq(16'h1013, 5'h12, 1'b0);
    run_seq(16'h1013, 5'h13, 1'b1);
    run_seq(16'h1234, 5'h10, 1'b0);
    // Bench-driven faults on drive B
    {pwr, son, run, inc, mta} <= 5'h10;
    xfer(8'h01, 32'h00002000, 8'h02, 16'h1008, 8'h01, 16'h0000);
    xfer(8'h01, 32'h00002001, 8'h02, 16'h0001, 8'h03, 16'h0005);
    xfer(8'h01, 32'h00002000, 8'h02, 16'h0000, 8'h01, 16'h0000);
    xfer(8'h00, 32'h00002001, 8'h02, 16'h0000, 8'h01, 16'h0000);
    xfer(8'h02, 32'h00002000, 8'h02, 16'h1008, 8'h03, 16'h0001);
    xfer(8'h01, 32'h00003000, 8'h02, 16'h0000, 8'h03, 16'h0002);
    xfer(8'h01, 32'h00002000, 8'h04, 16'h100E, 8'h03, 16'h0003);
    xfer(8'h01, 32'h00002000, 8'h02, 16'h1234, 8'h03, 16'h0004);
    // Run with no completion ends in the run timeout
    xfer(8'h01, 32'h00002000, 8'h02, 16'h100E, 8'h01, 16'h0000);
    xfer(8'h01, 32'h00002001, 8'h02, 16'h0001, 8'h03, 16'h0008);
    check(starts_b, 1, "run starts");
    xfer(8'h01, 32'h00002000, 8'h02, 16'h0000, 8'h01, 16'h0000);
    // Idle selection expires after 200 cycles with one abort
    xfer(8'h01, 32'h00002000, 8'h02, 16'h100E, 8'h01, 16'h0000);
    n = 0;
    repeat (215) begin
      @(posedge clock);
      n += (abort_b === 1'b1) ? 1 : 0;
    end
    check(n, 1, "abort pulses");
    xfer(8'h01, 32'h00002001, 8'h02, 16'h0001, 8'h03, 16'h0005);
    // Bad step value, then read back the kept selection
    xfer(8'h01, 32'h00002001, 8'h02, 16'h0003, 8'h03, 16'h0007);
    xfer(8'h00, 32'h00002000, 8'h02, 16'h0000, 8'h01, 16'h100E);
    complete_run();
  end
endmodule
